// file: hdl/ebus_pkg.sv
// Purpose: Constants and carriers for the external bus data/parity block
// Assumes: One 200 MHz clock, AHB-Lite register access
// Notes: Data bus lines numbered with line 0 as the MSB
// What this block does
// - 32-bit three-state data path, each access sized 8, 16 or 32 bits.
// - Data line zero carries MSB, line thirty-one carries LSB.
// - Parity lane n covers byte n from MSB; generated on writes, checked on reads.
// - Parity applies only to own transfers, never to external master transfers.
// - Parity enable and sense set per memory bank and for other slaves.
// - Each parity pin may instead act as an external interrupt request input.
// - Request 3 is AND of parity lane 0 and cancel reservation when both selected.
// - Request 4 is AND of parity lane 1 and kill reservation when both selected.
// - Request 6 is AND of parity lane 3 and freeze pin when both selected.
// - Internal arbiter: bus request is an input sampled from external masters.
// - External arbiter: drive bus request before each new transaction; never park.
// - Internal arbiter: drive grant when external request outranks internal requesters.
// - Drive bus busy only after seeing busy negated; wait for grant only with external arbiter.
package ebus_pkg;
    // ************************************************************
    // Register map
    // ************************************************************
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_PAR_EN = 8'h04;
    localparam logic [7:0] OFS_PAR_ODD = 8'h08;
    localparam logic [7:0] OFS_PINSEL = 8'h0C;
    localparam logic [7:0] OFS_STATUS = 8'h10;
    localparam logic [7:0] OFS_MASK = 8'h14;
    localparam logic [7:0] OFS_ERRCNT = 8'h18;
    localparam logic [7:0] OFS_PINS = 8'h1C;
    // CTRL fields
    localparam int CTRL_EXT_ARB = 0;
    localparam int CTRL_PRIO_LSB = 4;
    // PINSEL fields: bits 3:0 parity pins as irq, 4 cancel, 5 kill, 6 freeze
    localparam int SEL_CR = 4;
    localparam int SEL_KR = 5;
    localparam int SEL_FRZ = 6;
    // STATUS fields
    localparam int ST_PERR = 0;
    localparam int ST_XREQ = 1;
    localparam int ST_DONE = 2;
    localparam logic [31:0] RST_CTRL = 32'h0000_0000;
    localparam logic [31:0] RST_ZERO = 32'h0000_0000;
    localparam int NBANK = 8;
    localparam int NLANE = 4;
    localparam logic [3:0] BANK_OTHER = 4'h8;

    typedef enum logic [1:0] {
        SZ_BYTE = 2'h0,
        SZ_HALF = 2'h1,
        SZ_WORD = 2'h2
    } size_e;

    typedef struct packed {
        logic valid;
        logic write;
        logic [1:0] addr_lo;
        size_e size;
        logic [3:0] bank;
        logic [31:0] wdata;
    } xfer_req_s;

    typedef struct packed {
        logic [31:0] d_o;
        logic [31:0] d_oe;
        logic [3:0] p_o;
        logic [3:0] p_oe;
    } pin_drive_s;
endpackage

// file: hdl/lane_parity.sv
// Purpose: Parity for one byte lane
// Assumes: Odd or even sense chosen by caller
// Notes: Combinational
`timescale 1ns/1ps
module lane_parity
    import ebus_pkg::*;
(
    input wire logic [7:0] i_byte,
    input wire logic i_odd,
    input wire logic i_pin,
    output logic o_par,
    output logic o_bad
);
    always_comb begin
        o_par = ^i_byte ^ i_odd;
        o_bad = (o_par != i_pin);
    end
endmodule

// file: hdl/ebus_data_par.sv
// Purpose: External bus data path, lane parity, bus request, irq sharing
// Assumes: Pins synchronous to i_clk, AHB-Lite slave for registers
// Notes: Active-low pins carried as _n signals
`timescale 1ns/1ps
module ebus_data_par
    import ebus_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_hsel,
    input wire logic [7:0] i_haddr,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic [2:0] i_hsize,
    input wire logic [31:0] i_hwdata,
    input wire logic i_hready,
    output logic [31:0] o_hrdata,
    output logic o_hreadyout,
    output logic o_hresp,
    input wire xfer_req_s i_req,
    input wire logic i_int_req,
    input wire logic i_ack,
    output logic o_req_ready,
    output logic o_done,
    output logic [31:0] o_rdata,
    output logic o_perr,
    input wire logic [31:0] i_d,
    input wire logic [3:0] i_p,
    output pin_drive_s o_pins,
    input wire logic i_br_n,
    output logic o_br_n,
    output logic o_br_oe,
    input wire logic i_bg_n,
    output logic o_bg_n,
    output logic o_bg_oe,
    input wire logic i_bb_n,
    output logic o_bb_n,
    output logic o_bb_oe,
    input wire logic i_cr_n,
    input wire logic i_kr_n,
    input wire logic i_frz_n,
    output logic [3:0] o_ext_int_req,
    output logic o_irq
);
    // ************************************************************
    // Registers
    // ************************************************************
    logic [31:0] ctrl_q, ctrl_d, pen_q, pen_d, podd_q, podd_d;
    logic [31:0] sel_q, sel_d, mask_q, mask_d, cnt_q, cnt_d;
    logic [2:0] stat_q, stat_d;
    logic aw_q, aw_d, ar_q, ar_d;
    logic [7:0] aa_q, aa_d;
    logic [31:0] rd_q, rd_d;
    logic ext_arb;
    logic [2:0] ev;

    assign ext_arb = ctrl_q[CTRL_EXT_ARB];

    always_comb begin
        ctrl_d = ctrl_q;
        pen_d = pen_q;
        podd_d = podd_q;
        sel_d = sel_q;
        mask_d = mask_q;
        aw_d = 1'b0;
        ar_d = 1'b0;
        aa_d = aa_q;
        rd_d = rd_q;
        stat_d = stat_q | ev;
        if (aw_q) begin
            case (aa_q)
                OFS_CTRL: ctrl_d = i_hwdata;
                OFS_PAR_EN: pen_d = i_hwdata;
                OFS_PAR_ODD: podd_d = i_hwdata;
                OFS_PINSEL: sel_d = i_hwdata;
                OFS_MASK: mask_d = i_hwdata;
                default: ;
            endcase
        end
        if (ar_q && aa_q == OFS_STATUS) begin
            stat_d = ev;
        end
        if (i_hsel && i_hready && i_htrans[1]) begin
            aa_d = {i_haddr[7:2], 2'b00};
            aw_d = i_hwrite;
            ar_d = !i_hwrite;
            case ({i_haddr[7:2], 2'b00})
                OFS_CTRL: rd_d = ctrl_q;
                OFS_PAR_EN: rd_d = pen_q;
                OFS_PAR_ODD: rd_d = podd_q;
                OFS_PINSEL: rd_d = sel_q;
                OFS_STATUS: rd_d = {29'h0, stat_q};
                OFS_MASK: rd_d = mask_q;
                OFS_ERRCNT: rd_d = cnt_q;
                OFS_PINS: rd_d = {i_d[31:8], i_p, i_br_n, i_bg_n,
                    i_bb_n, ext_arb};
                default: rd_d = RST_ZERO;
            endcase
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ctrl_q <= RST_CTRL;
            pen_q <= RST_ZERO;
            podd_q <= RST_ZERO;
            sel_q <= RST_ZERO;
            mask_q <= RST_ZERO;
            stat_q <= 3'h0;
            aw_q <= 1'b0;
            ar_q <= 1'b0;
            aa_q <= 8'h00;
            rd_q <= RST_ZERO;
        end else begin
            ctrl_q <= ctrl_d;
            pen_q <= pen_d;
            podd_q <= podd_d;
            sel_q <= sel_d;
            mask_q <= mask_d;
            stat_q <= stat_d;
            aw_q <= aw_d;
            ar_q <= ar_d;
            aa_q <= aa_d;
            rd_q <= rd_d;
        end
    end

    assign o_hrdata = rd_q;
    assign o_hreadyout = 1'b1;
    assign o_hresp = 1'b0;
    assign o_irq = |(stat_q & mask_q[2:0]);

    // ************************************************************
    // Transfer state machine
    // ************************************************************
    typedef enum logic [3:0] {
        S_IDLE = 4'b0001,
        S_REQ = 4'b0010,
        S_BUSY = 4'b0100,
        S_DATA = 4'b1000
    } st_e;
    st_e st_q, st_d;
    xfer_req_s cur_q, cur_d;
    logic [31:0] rdat_q, rdat_d;
    logic perr_q, perr_d, done_q, done_d;
    logic [3:0] lanes, par, bad;
    logic [3:0] bsel;
    logic chk_en, odd_en;

    // Lane mask from size and address
    always_comb begin
        case (cur_q.size)
            SZ_BYTE: lanes = 4'b0001 << cur_q.addr_lo;
            SZ_HALF: lanes = cur_q.addr_lo[1] ? 4'b1100 : 4'b0011;
            default: lanes = 4'b1111;
        endcase
    end

    // Per-bank or other-slave parity setting
    assign bsel = cur_q.bank;
    assign chk_en = pen_q[bsel[3] ? NBANK : {1'b0, bsel[2:0]}];
    assign odd_en = podd_q[bsel[3] ? NBANK : {1'b0, bsel[2:0]}];

    // Lane k is data lines 8k..8k+7, line 0 the MSB
    for (genvar k = 0; k < NLANE; k++) begin : g_lane
        lane_parity u_par (
            .i_byte(cur_q.write ? cur_q.wdata[31-8*k -: 8]
                : i_d[31-8*k -: 8]),
            .i_odd(odd_en),
            .i_pin(i_p[k]),
            .o_par(par[k]),
            .o_bad(bad[k])
        );
    end

    always_comb begin
        st_d = st_q;
        cur_d = cur_q;
        rdat_d = rdat_q;
        perr_d = 1'b0;
        done_d = 1'b0;
        ev = 3'h0;
        case (st_q)
            S_IDLE: begin
                if (i_req.valid) begin
                    cur_d = i_req;
                    st_d = S_REQ;
                end
            end
            S_REQ: begin
                if (!ext_arb || !i_bg_n) begin
                    st_d = S_BUSY;
                end
            end
            S_BUSY: begin
                if (i_bb_n) begin
                    st_d = S_DATA;
                end
            end
            S_DATA: begin
                if (i_ack) begin
                    rdat_d = i_d;
                    // Only own reads, only lanes in transfer
                    perr_d = !cur_q.write && chk_en &&
                        |(bad & lanes);
                    done_d = 1'b1;
                    ev[ST_DONE] = 1'b1;
                    ev[ST_PERR] = perr_d;
                    st_d = S_IDLE;
                end
            end
            default: st_d = S_IDLE;
        endcase
        if (!ext_arb && !i_br_n) begin
            ev[ST_XREQ] = 1'b1;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st_q <= S_IDLE;
            cur_q <= '0;
            rdat_q <= RST_ZERO;
            perr_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            st_q <= st_d;
            cur_q <= cur_d;
            rdat_q <= rdat_d;
            perr_q <= perr_d;
            done_q <= done_d;
        end
    end

    assign cnt_d = cnt_q + {31'h0, perr_q};
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cnt_q <= RST_ZERO;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    assign o_req_ready = (st_q == S_IDLE);
    assign o_done = done_q;
    assign o_rdata = rdat_q;
    assign o_perr = perr_q;

    // ************************************************************
    // Pins
    // ************************************************************
    logic drive_data;
    assign drive_data = (st_q == S_DATA) && cur_q.write;

    always_comb begin
        o_pins = '0;
        o_pins.d_o = cur_q.wdata;
        o_pins.d_oe = drive_data ? 32'hFFFF_FFFF : 32'h0000_0000;
        for (int k = 0; k < NLANE; k++) begin
            o_pins.p_o[k] = par[k];
            // Parity pin used as irq is never driven
            o_pins.p_oe[k] = drive_data && chk_en && lanes[k]
                && !sel_q[k];
        end
    end

    // Request driven low only while own transfer pending
    assign o_br_n = !(ext_arb && st_q == S_REQ);
    assign o_br_oe = ext_arb;
    // Grant when outside request outranks internal ones
    assign o_bg_oe = !ext_arb;
    assign o_bg_n = !(!ext_arb && !i_br_n && (st_q == S_IDLE
        || !i_int_req || ctrl_q[CTRL_PRIO_LSB]));
    assign o_bb_n = !(st_q == S_DATA);
    assign o_bb_oe = (st_q == S_DATA);

    // ************************************************************
    // Interrupt request sharing
    // ************************************************************
    always_comb begin
        o_ext_int_req[0] = (sel_q[0] ? i_p[0] : 1'b1)
            & (sel_q[SEL_CR] ? i_cr_n : 1'b1);
        o_ext_int_req[1] = (sel_q[1] ? i_p[1] : 1'b1)
            & (sel_q[SEL_KR] ? i_kr_n : 1'b1);
        o_ext_int_req[2] = sel_q[2] ? i_p[2] : 1'b1;
        o_ext_int_req[3] = (sel_q[3] ? i_p[3] : 1'b1)
            & (sel_q[SEL_FRZ] ? i_frz_n : 1'b1);
    end

    // ************************************************************
    // Checks
    // ************************************************************
    bb_after_free_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        $rose(st_q == S_DATA) |-> $past(i_bb_n))
        else $error("busy driven before line free");
    br_only_ext_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        !o_br_n |-> ext_arb && st_q == S_REQ)
        else $error("bus request parked or wrong mode");
    br_input_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        !ext_arb |-> !o_br_oe)
        else $error("request driven with internal arbiter");
    no_wr_err_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        done_d && cur_q.write |=> !o_perr)
        else $error("parity error on write");
    perr_cnt_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        o_perr |=> cnt_q == $past(cnt_q) + 32'h1)
        else $error("error count not bumped");
    lane_skip_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        done_d && (bad & lanes) == 4'h0 |=> !o_perr)
        else $error("unused lane flagged");
    ext_int_req_3_and_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        sel_q[0] && sel_q[SEL_CR] |-> o_ext_int_req[0] == (i_p[0] & i_cr_n))
        else $error("request 3 not combined");
    ext_int_req_6_and_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        sel_q[3] && sel_q[SEL_FRZ] |->
        o_ext_int_req[3] == (i_p[3] & i_frz_n))
        else $error("request 6 not combined");
    par_oe_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        o_pins.p_oe[0] |-> !sel_q[0] && drive_data)
        else $error("parity pin driven while irq");
    grant_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        !o_bg_n |-> !ext_arb && !i_br_n)
        else $error("grant without request");
    rd_done_c: cover property (@(posedge i_clk) disable iff (!i_rst_n)
        o_done && !cur_q.write);
    perr_c: cover property (@(posedge i_clk) disable iff (!i_rst_n) o_perr);
    grant_c: cover property (@(posedge i_clk) disable iff (!i_rst_n)
        !o_bg_n);
endmodule

// file: tb/ebus_far_end.sv
// Purpose: Far side of the external bus: slave, arbiter, pull-ups
// Assumes: Answers once the block drives busy low
// Notes: Released lines toggle or go to their pull level
`timescale 1ns/1ps
module ebus_far_end
    import ebus_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire pin_drive_s i_pins,
    input wire logic i_br_n,
    input wire logic i_br_oe,
    input wire logic i_bg_n,
    input wire logic i_bg_oe,
    input wire logic i_bb_n,
    input wire logic i_bb_oe,
    input wire logic i_odd,
    input wire logic [31:0] i_rdata,
    input wire logic [3:0] i_bad,
    input wire logic [1:0] i_wait,
    input wire logic i_xbr_n,
    input wire logic i_hold,
    input wire logic [3:0] i_pidle,
    output logic [31:0] o_d,
    output logic [3:0] o_p,
    output logic o_ack,
    output logic o_br_n,
    output logic o_bg_n,
    output logic o_bb_n
);
    // ************************************************************
    // Slave and arbiter
    // ************************************************************
    logic [31:0] md_q;
    logic [3:0] mp_q, par;
    logic ack_q, bg_q;
    logic [1:0] cnt_q;
    always_comb begin
        for (int k = 0; k < 4; k++) begin
            par[k] = ^i_rdata[31-8*k -: 8] ^ i_odd ^ i_bad[k];
        end
    end
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            md_q <= 32'h0;
            mp_q <= 4'h0;
            ack_q <= 1'b0;
            bg_q <= 1'b1;
            cnt_q <= 2'h0;
        end else begin
            bg_q <= !(i_br_oe && !i_br_n);
            ack_q <= 1'b0;
            md_q <= ~md_q;
            if (i_bb_oe && !i_bb_n && !ack_q) begin
                cnt_q <= cnt_q + 2'h1;
                if (cnt_q == i_wait) begin
                    ack_q <= 1'b1;
                    md_q <= i_rdata;
                    mp_q <= par;
                    cnt_q <= 2'h0;
                end
            end
        end
    end
    assign o_d = (i_pins.d_oe & i_pins.d_o) | (~i_pins.d_oe & md_q);
    assign o_p = (i_pins.p_oe & i_pins.p_o)
        | (~i_pins.p_oe & (ack_q ? mp_q : i_pidle));
    assign o_ack = ack_q;
    assign o_br_n = i_br_oe ? i_br_n : i_xbr_n;
    assign o_bg_n = i_bg_oe ? i_bg_n : bg_q;
    assign o_bb_n = i_bb_oe ? i_bb_n : !i_hold;
endmodule

// file: tb/ext_bus_data_parity_request_test.sv
// Purpose: Self-checking bench for the external bus data/parity block
// Assumes: Zero-wait register bus, partner model on the pins
// Notes: Expectations come from the bench's own model
`timescale 1ns/1ps
module ext_bus_data_parity_request_test;
    import ebus_pkg::*;
    logic clk = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic [7:0] haddr = 8'h0;
    logic [1:0] htrans = 2'h0;
    logic [31:0] hwdata = 32'h0, hrdata, rdata, d, rdata_m = 32'h0, v32;
    logic hreadyout, hresp, req_ready, done, perr, irq, int_req = 1'b0;
    xfer_req_s req = '0;
    pin_drive_s pins;
    logic [3:0] p, bad_m = 4'h0, pidle = 4'hF, xint;
    logic ack, br_n, br_oe, bg_n, bg_oe, bb_n, bb_oe, obr, obg, obb;
    logic odd_p = 1'b0, xbr_n = 1'b1, hold_m = 1'b0;
    logic cr_n = 1'b1, kr_n = 1'b1, frz_n = 1'b1;
    logic [1:0] wait_m = 2'h0;
    logic [8:0] en_m, odd_m;
    int num_errors = 0, compares = 0, perrs = 0, i, k, s, v;
    always #2.5 clk = ~clk;
    ebus_data_par i_dut (.i_clk(clk), .i_rst_n(rst_n), .i_hsel(hsel),
        .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite),
        .i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(hreadyout),
        .o_hrdata(hrdata), .o_hreadyout(hreadyout), .o_hresp(hresp),
        .i_req(req), .i_int_req(int_req), .i_ack(ack),
        .o_req_ready(req_ready), .o_done(done), .o_rdata(rdata),
        .o_perr(perr), .i_d(d), .i_p(p), .o_pins(pins), .i_br_n(br_n),
        .o_br_n(obr), .o_br_oe(br_oe), .i_bg_n(bg_n), .o_bg_n(obg),
        .o_bg_oe(bg_oe), .i_bb_n(bb_n), .o_bb_n(obb), .o_bb_oe(bb_oe),
        .i_cr_n(cr_n), .i_kr_n(kr_n), .i_frz_n(frz_n),
        .o_ext_int_req(xint), .o_irq(irq));
    ebus_far_end i_far (.i_clk(clk), .i_rst_n(rst_n), .i_pins(pins),
        .i_br_n(obr), .i_br_oe(br_oe), .i_bg_n(obg), .i_bg_oe(bg_oe),
        .i_bb_n(obb), .i_bb_oe(bb_oe), .i_odd(odd_p), .i_rdata(rdata_m),
        .i_bad(bad_m), .i_wait(wait_m), .i_xbr_n(xbr_n), .i_hold(hold_m),
        .i_pidle(pidle), .o_d(d), .o_p(p), .o_ack(ack), .o_br_n(br_n),
        .o_bg_n(bg_n), .o_bb_n(bb_n));
    // ************************************************************
    // Tasks
    // ************************************************************
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            num_errors++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    task ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        logic rdy;
        hsel <= 1'b1; haddr <= a; htrans <= 2'h2; hwrite <= w;
        do begin
            @(negedge clk); rdy = hreadyout; @(posedge clk);
        end while (rdy !== 1'b1);
        hsel <= 1'b0; htrans <= 2'h0; hwdata <= wd;
        do begin
            @(negedge clk); rdy = hreadyout; v32 = hrdata; @(posedge clk);
        end while (rdy !== 1'b1);
    endtask
    task xfer(input logic w, input int bank, input int sz, input int alo,
              input logic [31:0] dat, input logic [3:0] bad, input int hold);
        logic [3:0] ln, xp, enl;
        logic rdy, brs, seen;
        int n;
        ln = sz == 2 ? 4'hF : sz == 1 ? (alo > 1 ? 4'hC : 4'h3) : 4'h1 << alo;
        enl = {4{en_m[bank]}};
        for (n = 0; n < 4; n++) xp[n] = ^dat[31-8*n -: 8] ^ odd_m[bank];
        rdata_m <= dat; bad_m <= bad; odd_p <= odd_m[bank];
        hold_m <= hold != 0; wait_m <= 2'($urandom_range(3, 0));
        req <= '{1'b1, w, 2'(alo), size_e'(sz), 4'(bank), dat};
        do begin
            @(negedge clk); rdy = req_ready; @(posedge clk);
        end while (rdy !== 1'b1);
        req.valid <= 1'b0;
        brs = 1'b0; seen = 1'b0;
        for (n = 0; n < 200 && done !== 1'b1; n++) begin
            @(negedge clk);
            if (br_oe && !obr) brs = 1'b1;
            if (n < hold) chk("bb_oe", 0, bb_oe);
            if (n == hold) hold_m <= 1'b0;
            if (bb_oe && !obb && !seen) begin
                seen = 1'b1;
                chk("br", 1, brs);
                if (w) chk("p_oe", ln & enl, pins.p_oe);
                if (w) chk("p_o", xp & ln & enl, pins.p_o & pins.p_oe);
                if (w && sz == 2) chk("d_o", dat, pins.d_o);
            end
        end
        chk("done", 1, done);
        if (!w) chk("perr", en_m[bank] && |(bad & ln), perr);
        if (!w && sz == 2) chk("rdata", dat, rdata);
        if (!w && en_m[bank] && |(bad & ln)) perrs++;
        repeat (2) @(negedge clk);
        chk("park", 1, obr | !br_oe);
        @(posedge clk);
    endtask
    task results;
        $display("Comparisons %0d mismatches %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial begin
        repeat (30000) @(posedge clk);
        num_errors++;
        results();
    end
    // ************************************************************
    // Scenarios
    // ************************************************************
    initial begin
        void'($urandom(32'h5344));
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        for (i = 0; i < 7; i++) begin
            ahb(0, 8'(i * 4), 0); chk("reg", 0, v32);
        end
        ahb(1, 8'h20, 32'hFFFFFFFF); ahb(0, 8'h20, 0); chk("unmapped", 0, v32);
        en_m = 9'($urandom) | 9'h100; odd_m = 9'($urandom);
        ahb(1, OFS_CTRL, 32'h1); ahb(1, OFS_PAR_EN, 32'(en_m));
        ahb(1, OFS_PAR_ODD, 32'(odd_m)); ahb(1, OFS_MASK, 32'h1);
        ahb(0, OFS_PAR_ODD, 0); chk("odd", 32'(odd_m), v32);
        for (i = 0; i < 40; i++) begin
            s = $urandom_range(2, 0);
            v = s == 2 ? 0 : s == 1 ? 2 * $urandom_range(1, 0) : $urandom_range(3, 0);
            xfer(1'($urandom), $urandom_range(8, 0), s, v, $urandom,
                 4'($urandom), i == 5 ? 4 : 0);
        end
        xfer(0, 8, 2, 0, $urandom, 4'h2, 0);
        @(negedge clk); chk("irq", 1, irq);
        @(posedge clk); ahb(0, OFS_STATUS, 0);
        chk("status", 32'h5, v32 & 32'h5);
        @(negedge clk); chk("irq_clr", 0, irq);
        @(posedge clk); ahb(1, OFS_MASK, 32'h0);
        xfer(0, 8, 1, 2, $urandom, 4'h4, 0);
        @(negedge clk); chk("irq_mask", 0, irq);
        @(posedge clk); ahb(1, OFS_MASK, 32'h4);
        @(negedge clk); chk("irq_done", 1, irq);
        @(posedge clk); ahb(0, OFS_ERRCNT, 0);
        chk("errcnt", 32'(perrs), v32);
        @(posedge clk); ahb(1, OFS_CTRL, 32'h0);
        xbr_n <= 1'b0;
        repeat (4) @(posedge clk);
        @(negedge clk); chk("grant", 2'b10, {bg_oe, obg});
        @(posedge clk); xbr_n <= 1'b1; ahb(0, OFS_STATUS, 0);
        chk("xreq", 1, v32[ST_XREQ]);
        for (k = 0; k < 4; k++) for (s = 0; s < 4; s++) begin
            ahb(1, OFS_PINSEL, (s % 2) << k | (k != 2 && s > 1) << (k + 4 - k / 3));
            for (v = 0; v < 4; v++) begin
                pidle <= 4'hF ^ ((v % 2 == 0) << k);
                {cr_n, kr_n, frz_n} <= {3{v > 1}};
                repeat (4) @(posedge clk);
                @(negedge clk);
                chk("int_req", (s % 2 == 0 || v % 2) && (k == 2 || s < 2 || v > 1), xint[k]);
                @(posedge clk);
            end
        end
        results();
    end
endmodule
